// ===== hw/step_pulse_and_servo_loop.v
// Purpose: one axis of step/direction generation and servo position loop
// Assumes: register bus strobes are one cycle; encoder count is given
// Notes: velocities are counts per profile tick, in 16.16 fixed point
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "step_servo_consts.vh"

// Operation
// - Step pulses high HALF_PULSE cycles, low at least 2*HALF_PULSE+2
// - Stepper axis claims auxiliary encoder input
// - Commanded step position reported beside encoder count
// - Smoothing level 0.25 to 64 filters rate
// - Profiler drives steps with shared parameters
// - Stepper runs open loop, no error
// - Kind 2 active high, -2 active low
// - Servo filter sums damping, linear, sum
// - Damping gain limited to 4095
// - Linear gain limited to 1023
// - Integrator drives steady error to zero
// - Error equals commanded minus encoder position
// - Enabled axis switches off past limit
// - Velocity mode ramps to new signed speed
// - Halt brings motion to a stop
// - Position redefinable; absolute moves follow origin
// - Start any subset of axes together
module step_pulse_and_servo_loop #(
  parameter integer TICK_CYCLES = `TICK_CYC,
  parameter integer HALF_PULSE = 4
) (
  input wire clk,
  input wire reset,
  input wire [7:0] addr,
  input wire [31:0] wrData,
  input wire wrStb,
  input wire rdStb,
  output reg [31:0] rdData,
  input wire startSync,
  input wire [31:0] shaftCount,
  output wire auxEncClaim,
  output wire pulse_out_x,
  output wire heading_out_x,
  output reg [15:0] motorCmd,
  output wire ampEnable,
  output wire irq
);

  // ****************************************
  // Registers
  // ****************************************
  reg [5:0] ctrl_q;
  reg [7:0] kind_q;
  reg signed [31:0] target_q;
  reg signed [31:0] speed_q;
  reg [31:0] accel_q;
  reg [31:0] decel_q;
  reg [8:0] smooth_q;
  reg [11:0] dGain_q;
  reg [9:0] pGain_q;
  reg [9:0] iGain_q;
  reg [31:0] limit_q;
  reg [2:0] irqSt_q;
  reg [2:0] irqMask_q;
  reg signed [47:0] pos_q;
  reg signed [31:0] vel_q;
  reg signed [31:0] velSm_q;
  reg moving_q;
  reg driveOn_q;
  reg [31:0] tick_q;
  reg [31:0] stepPos_q;
  reg dir_q;
  reg pulse_q;
  reg [3:0] pw_q;
  reg [1:0] pstate_q;
  reg signed [31:0] errPrev_q;
  reg signed [47:0] integ_q;
  reg signed [31:0] encOfs_q;
  reg [2:0] ev_q;
  reg halt_q;

  localparam [1:0] P_IDLE = 2'h0;
  localparam [1:0] P_SETUP = 2'h1;
  localparam [1:0] P_HIGH = 2'h2;
  localparam [1:0] P_LOW = 2'h3;

  wire isStep = (kind_q == `KIND_STEP_HI) || (kind_q == `KIND_STEP_LO);
  wire tick = (tick_q == 32'h0);
  wire signed [31:0] cmdPos = pos_q[47:16];
  wire signed [31:0] encPos = $signed(shaftCount) - encOfs_q;
  // Open loop: no error for a stepper
  wire signed [31:0] gap = isStep ? 32'h0 : cmdPos - encPos;
  wire [31:0] gapAbs = gap[31] ? -gap : gap;
  wire writeCtl = wrStb && (addr == `A_CTRL);
  wire doBegin = (writeCtl && wrData[`C_BEGIN]) || startSync;
  wire doHalt = writeCtl && wrData[`C_HALT];

  function [31:0] clampU;
    input [31:0] v;
    input [31:0] mx;
    begin
      clampU = (v > mx) ? mx : v;
    end
  endfunction

  wire [31:0] smoothClamp = clampU(wrData, {23'h0, `SMOOTH_MAX});
  wire [31:0] dGainClamp = clampU(wrData, {20'h0, `DGAIN_MAX});
  wire [31:0] pGainClamp = clampU(wrData, {22'h0, `PGAIN_MAX});

  assign auxEncClaim = isStep;
  assign heading_out_x = dir_q;
  // Polarity from kind code
  assign pulse_out_x = (kind_q == `KIND_STEP_LO) ? ~pulse_q : pulse_q;
  assign ampEnable = driveOn_q;
  assign irq = |(irqSt_q & irqMask_q);

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      ctrl_q <= 6'h0;
      kind_q <= `KIND_SERVO;
      target_q <= 32'h0;
      speed_q <= 32'h0;
      accel_q <= 32'h0;
      decel_q <= 32'h0;
      smooth_q <= `SMOOTH_MIN;
      dGain_q <= 12'h0;
      pGain_q <= 10'h0;
      iGain_q <= 10'h0;
      limit_q <= 32'hffffffff;
      irqMask_q <= 3'h0;
    end else if (wrStb) begin
      if (addr == `A_CTRL) begin
        ctrl_q <= wrData[5:0];
      end else if (addr == `A_KIND) begin
        kind_q <= wrData[7:0];
      end else if (addr == `A_TARGET) begin
        target_q <= wrData;
      end else if (addr == `A_SPEED) begin
        speed_q <= wrData;
      end else if (addr == `A_ACCEL) begin
        accel_q <= wrData;
      end else if (addr == `A_DECEL) begin
        decel_q <= wrData;
      end else if (addr == `A_SMOOTH) begin
        // Quarter steps: 1 is 0.25, 256 is 64; zero would stall the filter
        smooth_q <= (smoothClamp == 32'h0) ? `SMOOTH_MIN :
          smoothClamp[8:0];
      end else if (addr == `A_DGAIN) begin
        dGain_q <= dGainClamp[11:0];
      end else if (addr == `A_PGAIN) begin
        pGain_q <= pGainClamp[9:0];
      end else if (addr == `A_IGAIN) begin
        iGain_q <= wrData[9:0];
      end else if (addr == `A_LIMIT) begin
        limit_q <= wrData;
      end else if (addr == `A_IRQMASK) begin
        irqMask_q <= wrData[2:0];
      end
    end
  end

  // ****************************************
  // Interrupt status, set wins over clear
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      irqSt_q <= 3'h0;
    end else begin
      irqSt_q <= (irqSt_q & ~((wrStb && addr == `A_IRQST) ?
        wrData[2:0] : 3'h0)) | ev_q;
    end
  end

  // ****************************************
  // Trajectory profiler
  // ****************************************
  reg signed [31:0] goal;
  reg signed [31:0] remain;
  reg signed [63:0] stopDist;
  always @* begin
    remain = target_q - cmdPos;
    stopDist = ($signed({32'h0, vel_q[31] ? -vel_q : vel_q}) *
      $signed({32'h0, vel_q[31] ? -vel_q : vel_q})) /
      $signed({32'h0, (decel_q == 0) ? 32'h1 : decel_q});
    if (!moving_q) begin
      goal = 32'h0;
    end else if (halt_q) begin
      goal = 32'h0;
    end else if (ctrl_q[`C_JOG]) begin
      goal = speed_q;
    end else if (remain == 0 ||
      ($signed({{32{remain[31]}}, remain}) * (remain[31] ? -1 : 1)) * 2
      <= (stopDist >>> 16)) begin
      goal = 32'h0;
    end else begin
      goal = remain[31] ? -speed_q : speed_q;
    end
  end

  wire signed [31:0] accStep = (goal == 0 ||
    (goal[31] != vel_q[31] && vel_q != 0)) ? decel_q : accel_q;
  wire signed [31:0] velNext = (goal > vel_q) ?
    ((goal - vel_q > accStep) ? vel_q + accStep : goal) :
    ((vel_q - goal > accStep) ? vel_q - accStep : goal);

  always @(posedge clk) begin
    if (reset) begin
      tick_q <= 32'h0;
      pos_q <= 48'h0;
      vel_q <= 32'h0;
      velSm_q <= 32'h0;
      moving_q <= 1'b0;
      encOfs_q <= 32'h0;
      ev_q <= 3'h0;
    end else begin
      ev_q <= 3'h0;
      tick_q <= tick ? TICK_CYCLES - 1 : tick_q - 32'h1;
      if (wrStb && addr == `A_DEFPOS) begin
        pos_q <= {wrData, 16'h0};
        encOfs_q <= $signed(shaftCount) - $signed(wrData);
      end else if (tick) begin
        vel_q <= velNext;
        // First-order filter; larger level is slower response
        velSm_q <= velSm_q + ((velNext - velSm_q) * 4 /
          $signed({23'h0, smooth_q}));
        pos_q <= pos_q + {{16{velSm_q[31]}}, velSm_q};
        if (moving_q && goal == 0 && velNext == 0 && velSm_q == 0) begin
          moving_q <= 1'b0;
          ev_q[`EV_DONE] <= 1'b1;
        end
      end
      if (doBegin) begin
        moving_q <= 1'b1;
      end
      if (doHalt && moving_q) begin
        ev_q[`EV_HALTED] <= 1'b1;
      end
      if (driveOn_q && !isStep && ctrl_q[`C_OFFEN] && gapAbs > limit_q) begin
        ev_q[`EV_OFF] <= 1'b1;
      end
    end
  end

  // Halt pins the goal at zero until the next begin, so the
  // profiler decelerates on the programmed ramp instead of jumping
  always @(posedge clk) begin
    if (reset) begin
      halt_q <= 1'b0;
    end else if (doHalt) begin
      halt_q <= 1'b1;
    end else if (doBegin) begin
      halt_q <= 1'b0;
    end
  end

  // ****************************************
  // Step pulse generator
  // ****************************************
  wire stepDue = isStep && (cmdPos != $signed(stepPos_q));
  wire wantDir = cmdPos > $signed(stepPos_q);
  always @(posedge clk) begin
    if (reset) begin
      stepPos_q <= 32'h0;
      dir_q <= 1'b0;
      pulse_q <= 1'b0;
      pw_q <= 4'h0;
      pstate_q <= P_IDLE;
    end else begin
      if (wrStb && addr == `A_DEFPOS) begin
        stepPos_q <= wrData;
      end
      case (pstate_q)
        P_IDLE: begin
          if (stepDue) begin
            dir_q <= wantDir;
            pw_q <= HALF_PULSE[3:0];
            pstate_q <= P_SETUP;
          end
        end
        P_SETUP: begin
          if (pw_q == 4'h0) begin
            pulse_q <= 1'b1;
            pw_q <= HALF_PULSE[3:0] - 4'h1;
            pstate_q <= P_HIGH;
          end else begin
            pw_q <= pw_q - 4'h1;
          end
        end
        P_HIGH: begin
          if (pw_q == 4'h0) begin
            pulse_q <= 1'b0;
            pw_q <= HALF_PULSE[3:0] - 4'h1;
            stepPos_q <= dir_q ? stepPos_q + 32'h1 : stepPos_q - 32'h1;
            pstate_q <= P_LOW;
          end else begin
            pw_q <= pw_q - 4'h1;
          end
        end
        default: begin
          if (pw_q == 4'h0) begin
            pstate_q <= P_IDLE;
          end else begin
            pw_q <= pw_q - 4'h1;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Servo filter
  // ****************************************
  wire signed [47:0] pTerm = gap * $signed({1'b0, pGain_q});
  wire signed [47:0] dTerm = (gap - errPrev_q) * $signed({1'b0, dGain_q});
  wire signed [47:0] sum = pTerm + dTerm + (integ_q >>> 8);
  always @(posedge clk) begin
    if (reset) begin
      errPrev_q <= 32'h0;
      integ_q <= 48'h0;
      motorCmd <= 16'h0;
      driveOn_q <= 1'b0;
    end else begin
      if (ev_q[`EV_OFF]) begin
        driveOn_q <= 1'b0;
      end else if (wrStb && addr == `A_CTRL) begin
        driveOn_q <= wrData[`C_SERVOON];
      end
      if (tick) begin
        errPrev_q <= gap;
        if (iGain_q != 10'h0 && driveOn_q && !isStep) begin
          integ_q <= integ_q + gap * $signed({1'b0, iGain_q});
        end
        if (!driveOn_q || isStep) begin
          motorCmd <= 16'h0;
        end else if (sum > 48'sh7fff) begin
          motorCmd <= 16'h7fff;
        end else if (sum < -48'sh8000) begin
          motorCmd <= 16'h8000;
        end else begin
          motorCmd <= sum[15:0];
        end
      end
    end
  end

  // ****************************************
  // Register reads, data one cycle later
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      rdData <= 32'h0;
    end else if (rdStb) begin
      if (addr == `A_CTRL) begin
        rdData <= {26'h0, ctrl_q};
      end else if (addr == `A_KIND) begin
        rdData <= {24'h0, kind_q};
      end else if (addr == `A_TARGET) begin
        rdData <= target_q;
      end else if (addr == `A_SPEED) begin
        rdData <= speed_q;
      end else if (addr == `A_SMOOTH) begin
        rdData <= {23'h0, smooth_q};
      end else if (addr == `A_DGAIN) begin
        rdData <= {20'h0, dGain_q};
      end else if (addr == `A_PGAIN) begin
        rdData <= {22'h0, pGain_q};
      end else if (addr == `A_IGAIN) begin
        rdData <= {22'h0, iGain_q};
      end else if (addr == `A_LIMIT) begin
        rdData <= limit_q;
      end else if (addr == `A_CMDPOS) begin
        rdData <= isStep ? stepPos_q : cmdPos;
      end else if (addr == `A_SHAFT) begin
        rdData <= encPos;
      end else if (addr == `A_GAP) begin
        rdData <= gap;
      end else if (addr == `A_STATUS) begin
        rdData <= {28'h0, isStep, dir_q, driveOn_q, moving_q};
      end else if (addr == `A_IRQST) begin
        rdData <= {29'h0, irqSt_q};
      end else if (addr == `A_IRQMASK) begin
        rdData <= {29'h0, irqMask_q};
      end else begin
        rdData <= 32'h0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== common/step_servo_consts.vh
// Purpose: shared constants for the step pulse and servo loop block
// Assumes: 32-bit register bus, word addresses in bytes
// Notes: offsets are byte addresses
`ifndef STEP_SERVO_CONSTS_VH
`define STEP_SERVO_CONSTS_VH
`define A_CTRL 8'h00
`define A_KIND 8'h04
`define A_TARGET 8'h08
`define A_SPEED 8'h0c
`define A_ACCEL 8'h10
`define A_DECEL 8'h14
`define A_SMOOTH 8'h18
`define A_DGAIN 8'h1c
`define A_PGAIN 8'h20
`define A_IGAIN 8'h24
`define A_LIMIT 8'h28
`define A_DEFPOS 8'h2c
`define A_CMDPOS 8'h30
`define A_SHAFT 8'h34
`define A_GAP 8'h38
`define A_STATUS 8'h3c
`define A_IRQST 8'h40
`define A_IRQMASK 8'h44
`define A_DRIVE 8'h48
`define C_BEGIN 0
`define C_HALT 1
`define C_JOG 2
`define C_ABS 3
`define C_OFFEN 4
`define C_SERVOON 5
`define KIND_STEP_HI 8'h02
`define KIND_STEP_LO 8'hfe
`define KIND_SERVO 8'h01
`define DGAIN_MAX 12'hfff
`define PGAIN_MAX 10'h3ff
`define SMOOTH_MIN 9'h001
`define SMOOTH_MAX 9'h100
`define TICK_NS 1000
`define CLK_NS 4
`define TICK_CYC ((`TICK_NS) / (`CLK_NS))
`define EV_DONE 0
`define EV_OFF 1
`define EV_HALTED 2
`endif

// ===== testbench/step_servo_properties.sv
// Purpose: port checks for step_pulse_and_servo_loop
// Assumes: HALF_PULSE matches the bound instance
// Notes: kind and mask are mirrored from bus writes
`timescale 1ns/1ns
`default_nettype none
`include "step_servo_consts.vh"
module step_servo_properties #(
  parameter integer HALF_PULSE = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [31:0] rdData,
  input wire logic auxEncClaim,
  input wire logic pulse_out_x,
  input wire logic heading_out_x,
  input wire logic irq
);
  // ********
  // Mirrors
  // ********
  logic [7:0] kindQ, kindP, maskQ, hiRun, loRun;
  wire isStep = kindQ == `KIND_STEP_HI || kindQ == `KIND_STEP_LO;
  // Blanked while the kind settles, so a polarity swap is no pulse
  wire act = isStep && kindQ == kindP &&
    (pulse_out_x ^ (kindQ == `KIND_STEP_LO));
  always @(posedge clk) begin
    kindP <= kindQ;
    hiRun <= act ? hiRun + 8'h01 : 8'h00;
    if (act)
      loRun <= 8'h00;
    else if (loRun != 8'hff)
      loRun <= loRun + 8'h01;
    if (reset) begin
      kindQ <= `KIND_SERVO;
      kindP <= `KIND_SERVO;
      maskQ <= 8'h00;
      hiRun <= 8'h00;
      loRun <= 8'hff;
    end else if (wrStb && addr == `A_KIND)
      kindQ <= wrData[7:0];
    else if (wrStb && addr == `A_IRQMASK)
      maskQ <= wrData[7:0];
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence sRise;
    !act ##1 act;
  endsequence
  sequence sHeld;
    act ##1 act;
  endsequence
  AST_CLAIM: assert property (auxEncClaim == isStep)
    else $error("encoder claim differs from kind");
  AST_SERVO_QUIET: assert property (!isStep && $past(!isStep) |-> !pulse_out_x)
    else $error("step output moved in servo kind");
  AST_HIGH_TIME: assert property ($fell(act) |-> hiRun == HALF_PULSE)
    else $error("pulse active time wrong");
  AST_LOW_TIME: assert property ($rose(act) |-> loRun >= HALF_PULSE)
    else $error("pulse idle time too short");
  AST_DIR_SETUP: assert property (sRise |-> $stable(heading_out_x))
    else $error("direction moved at pulse start");
  AST_DIR_HOLD: assert property (sHeld |-> $stable(heading_out_x))
    else $error("direction moved inside pulse");
  AST_UNMAPPED: assert property (rdStb && addr > `A_DRIVE |=> rdData == 32'h0)
    else $error("unmapped read not zero");
  AST_GAP_STEP: assert property (rdStb && addr == `A_GAP && auxEncClaim |=> rdData == 32'h0)
    else $error("stepper reported an error value");
  AST_IRQ_MASK: assert property (maskQ == 8'h00 && $past(maskQ) == 8'h00 |-> !irq)
    else $error("irq high with all masked");
endmodule
`default_nettype wire

// ===== testbench/step_amp_model.sv
// Purpose: step amplifier and crude servo plant on the far side
// Assumes: one encoder count per step
// Notes: plant moves one count every other cycle by command sign
`timescale 1ns/1ns
`default_nettype none
module step_amp_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic pulse_out_x,
  input wire logic heading_out_x,
  input wire logic activeLow,
  input wire logic signed [15:0] motorCmd,
  input wire logic ampEnable,
  input wire logic [31:0] bump,
  output logic [31:0] shaftCount,
  output logic [31:0] steps
);
  // ********
  // Motor
  // ********
  logic actQ, slowQ;
  logic [31:0] posQ;
  wire act = pulse_out_x ^ activeLow;
  assign shaftCount = posQ + bump;
  always @(posedge clk) begin
    actQ <= act;
    slowQ <= ~slowQ;
    if (reset) begin
      posQ <= 32'h0;
      steps <= 32'h0;
      slowQ <= 1'b0;
    end else if (act && !actQ) begin
      steps <= heading_out_x ? steps + 32'h1 : steps - 32'h1;
      posQ <= heading_out_x ? posQ + 32'h1 : posQ - 32'h1;
    end else if (ampEnable && slowQ && motorCmd != 16'h0)
      posQ <= motorCmd[15] ? posQ - 32'h1 : posQ + 32'h1;
  end
endmodule
`default_nettype wire

// ===== testbench/step_pulse_and_servo_loop_bench.sv
// Purpose: directed bench for step_pulse_and_servo_loop
// Assumes: short tick of 4 cycles, pulse half of 4
// Notes: status bits are cleared after every awaited event
`timescale 1ns/1ns
`default_nettype none
`include "step_servo_consts.vh"
module step_pulse_and_servo_loop_bench;
  logic clk = 0, reset = 1, wrStb = 0, rdStb = 0, startSync = 0;
  logic activeLow = 0, auxEncClaim, pulse_out_x, heading_out_x;
  logic ampEnable, irq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wrData = 32'h0, bump = 32'h0, rdData, shaftCount;
  logic [31:0] steps, q, s0;
  logic [15:0] motorCmd;
  int errTotal = 0, nChecks = 0, cyc = 0, i;
  always #2 clk = ~clk;
  step_pulse_and_servo_loop #(.TICK_CYCLES(4), .HALF_PULSE(4)) DUT (
    .clk(clk), .reset(reset), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .startSync(startSync), .shaftCount(shaftCount),
    .auxEncClaim(auxEncClaim), .pulse_out_x(pulse_out_x),
    .heading_out_x(heading_out_x), .motorCmd(motorCmd),
    .ampEnable(ampEnable), .irq(irq));
  step_amp_model M (.clk(clk), .reset(reset), .pulse_out_x(pulse_out_x),
    .heading_out_x(heading_out_x), .activeLow(activeLow),
    .motorCmd(motorCmd), .ampEnable(ampEnable), .bump(bump),
    .shaftCount(shaftCount), .steps(steps));
  // ********
  // Bus and checks
  // ********
  task automatic chk(input string n, input logic [31:0] s, e);
    nChecks++;
    if (s !== e) begin
      errTotal++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 q = rdData;
  endtask
  task automatic wrd(input logic [7:0] a, input logic [31:0] d, e);
    wr(a, d);
    rd(a);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic ev(input int b);
    q = 32'h0;
    for (i = 0; i < 3000 && q[b] !== 1'b1; i++)
      rd(`A_IRQST);
    chk("event", q[b], 1'b1);
    wr(`A_IRQST, 32'h7);
  endtask
  task automatic waitIrq(input logic v);
    for (i = 0; i < 3000 && irq !== v; i++)
      @(posedge clk);
    chk("irq", irq, v);
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    rd(`A_KIND);
    chk("kind", q, 32'h1);
    wrd(`A_DGAIN, 32'hffff, 32'hfff);
    wrd(`A_PGAIN, 32'hffff, 32'h3ff);
    wrd(`A_SMOOTH, 32'h0, 32'h1);
    wrd(`A_SMOOTH, 32'h200, 32'h100);
    wrd(8'h80, 32'hffff, 32'h0);
  endtask
  task automatic t_step;
    wr(`A_KIND, `KIND_STEP_HI);
    wr(`A_SPEED, 32'h4000);
    wr(`A_ACCEL, 32'h1000);
    wr(`A_DECEL, 32'h1000);
    wr(`A_SMOOTH, 32'h4);
    chk("claim", auxEncClaim, 1'b1);
    chk("idle", pulse_out_x, 1'b0);
    s0 = steps;
    wr(`A_TARGET, 32'd20);
    wr(`A_CTRL, 32'h1);
    ev(`EV_DONE);
    chk("steps", steps - s0, 32'd20);
    rd(`A_CMDPOS);
    chk("cmdpos", q, 32'd20);
    rd(`A_SHAFT);
    chk("shaft", q, shaftCount);
    rd(`A_GAP);
    chk("gap", q, 32'h0);
    wr(`A_DEFPOS, 32'd100);
    rd(`A_CMDPOS);
    chk("defpos", q, 32'd100);
    s0 = steps;
    wr(`A_TARGET, 32'd90);
    wr(`A_CTRL, 32'h9);
    ev(`EV_DONE);
    chk("abs", steps - s0, 32'hfffffff6);
    chk("heading", heading_out_x, 1'b0);
  endtask
  task automatic t_jog;
    wr(`A_CTRL, 32'h5);
    repeat (300) @(posedge clk);
    chk("fwd", heading_out_x, 1'b1);
    wr(`A_SPEED, 32'hffffc000);
    for (i = 0; i < 3000 && heading_out_x !== 1'b0; i++)
      @(posedge clk);
    s0 = steps;
    repeat (300) @(posedge clk);
    chk("rev", $signed(steps - s0) < 0, 1'b1);
    wr(`A_IRQMASK, 32'h4);
    wr(`A_CTRL, 32'h2);
    waitIrq(1'b1);
    ev(`EV_DONE);
    repeat (20) @(posedge clk);
    s0 = steps;
    repeat (200) @(posedge clk);
    chk("halted", steps, s0);
    wr(`A_IRQST, 32'h7);
    waitIrq(1'b0);
    wr(`A_IRQMASK, 32'h0);
    wr(`A_CTRL, 32'h0);
  endtask
  task automatic t_group;
    wr(`A_KIND, `KIND_STEP_LO);
    activeLow <= 1'b1;
    repeat (4) @(posedge clk);
    chk("idle", pulse_out_x, 1'b1);
    wr(`A_SPEED, 32'h4000);
    wr(`A_DEFPOS, 32'h0);
    wr(`A_TARGET, 32'd12);
    s0 = steps;
    @(posedge clk);
    startSync <= 1'b1;
    @(posedge clk);
    startSync <= 1'b0;
    ev(`EV_DONE);
    chk("group", steps - s0, 32'd12);
  endtask
  task automatic t_servo;
    wr(`A_KIND, `KIND_SERVO);
    activeLow <= 1'b0;
    wr(`A_DEFPOS, shaftCount);
    bump <= 32'd300;
    repeat (8) @(posedge clk);
    rd(`A_GAP);
    chk("gap", q, 32'hfffffed4);
    wr(`A_LIMIT, 32'd100);
    wr(`A_CTRL, 32'h30);
    ev(`EV_OFF);
    chk("amp", ampEnable, 1'b0);
    repeat (4) @(posedge clk);
    chk("cmd", motorCmd, 32'h0);
    wr(`A_LIMIT, 32'h7fffffff);
    wr(`A_DGAIN, 32'd40);
    wr(`A_PGAIN, 32'd10);
    wr(`A_IGAIN, 32'd1);
    wr(`A_CTRL, 32'h20);
    q = 32'h1;
    for (i = 0; i < 1500 && q !== 32'h0; i++)
      rd(`A_GAP);
    chk("settle", q, 32'h0);
  endtask
  task automatic closeOut;
    $display("Checks %0d errors %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      errTotal++;
      closeOut;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_step;
    t_jog;
    t_group;
    t_servo;
    closeOut;
  end
endmodule
bind step_pulse_and_servo_loop step_servo_properties #(
  .HALF_PULSE(HALF_PULSE)) chkProps (.clk(clk), .reset(reset),
  .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
  .rdData(rdData), .auxEncClaim(auxEncClaim),
  .pulse_out_x(pulse_out_x), .heading_out_x(heading_out_x), .irq(irq));
`default_nettype wire
